// ### include/gcgsc_map.svh
/*
 Register offsets, field positions and reset values of the port clock gating
 and sleep clock control block.
 Assumes a 12-bit APB byte address window and 32-bit data.
*/
`ifndef GCGSC_MAP_SVH
`define GCGSC_MAP_SVH

`define GCGSC_ADDR_W 12
`define GCGSC_NUM_PORTS 5

`define GCGSC_OFF_RUN_GATE 12'h108
`define GCGSC_OFF_SLEEP_GATE 12'h118
`define GCGSC_OFF_DSLP_GATE 12'h128
`define GCGSC_OFF_DSLP_SRC 12'h144
`define GCGSC_OFF_VERIFY_CLR 12'h150
`define GCGSC_OFF_LDO_RST 12'h160
`define GCGSC_OFF_AUX_CTRL 12'h170
`define GCGSC_OFF_IRQ_STATUS 12'h180
`define GCGSC_OFF_IRQ_MASK 12'h184

`define GCGSC_BIT_INTERNAL_OSC_SELECT 0
`define GCGSC_BIT_VERIFY_FAULT_CLEAR 0
`define GCGSC_BIT_REGULATOR_RESET 0
`define GCGSC_BIT_AUTO_GATING_SELECT 0

`define GCGSC_NUM_EVENTS 3
`define GCGSC_EV_VERIFY_FAULT 0
`define GCGSC_EV_REGULATOR_FAULT 1
`define GCGSC_EV_DEEP_EXIT 2

`define GCGSC_RST_GATE 5'h00
`define GCGSC_RST_BIT 1'h0
`define GCGSC_RST_EVENTS 3'h0

`endif

// ### include/gcgsc_pkg.sv
/*
 Types shared by the port clock gating and sleep clock control block.
 Assumes the map header is compiled alongside.
*/
package gcgsc_pkg;

   typedef enum logic [1:0] {
      GCGSC_SRC_MAIN = 2'h0,
      GCGSC_SRC_INT_OSC = 2'h1,
      GCGSC_SRC_PLL = 2'h2,
      GCGSC_SRC_ALT = 2'h3
   } gcgsc_osc_t;

   typedef struct packed {
      gcgsc_osc_t src;
      logic [3:0] sysdiv;
   } gcgsc_clk_cfg_t;

   typedef enum logic [2:0] {
      GCGSC_ST_RUN = 3'b001,
      GCGSC_ST_SLEEP = 3'b010,
      GCGSC_ST_DEEP = 3'b100
   } gcgsc_state_t;

   typedef struct packed {
      logic int_osc_power_up;
      logic main_osc_power_down;
   } gcgsc_osc_pwr_t;

endpackage : gcgsc_pkg

// ### src/gcgsc_top.sv
/*
 Port clock gating and sleep clock control: five latch-gated port clocks with
 run, sleep and deep-sleep enable sets, deep-sleep oscillator switch and
 restore, clock verification clear, regulator fault reset enable, interrupts.
 Assumes an APB master on mclk, core sleep signals on mclk, and fault inputs
 arriving asynchronously from analog circuitry.
*/

// Operation
// - Enable bit one clocks port, zero stops
// - Five port enables, first at bit zero
// - Access to unclocked port gives bus fault
// - All port enables reset to zero
// - Run, sleep, deep-sleep enable copies at offsets
// - Sleep copies apply only with auto gating
// - Unused upper bits ignored, software preserves them
// - Internal oscillator select used in deep sleep
// - Deep entry powers internal up, main down
// - Deep exit restores prior source and frequency
// - Select zero keeps main oscillator in deep
// - Active verify fault forces known good clock
// - Writing one clears all verify faults
// - Clear bit holds last written value
// - Enabled regulator fault resets the part
`timescale 1ns/1ps
`include "gcgsc_map.svh"

module gcgsc_top #(
   parameter int NUM_PORTS = `GCGSC_NUM_PORTS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GCGSC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic core_sleeping,
   input wire logic core_sleep_deep,
   input wire gcgsc_pkg::gcgsc_clk_cfg_t run_clk_cfg,
   output gcgsc_pkg::gcgsc_clk_cfg_t sys_clk_cfg,
   output gcgsc_pkg::gcgsc_osc_pwr_t osc_pwr,
   input wire logic clk_verify_fault,
   output logic verify_fault_clear,
   input wire logic regulator_unregulated,
   output logic part_reset_req,
   input wire logic [NUM_PORTS-1:0] port_access,
   output logic [NUM_PORTS-1:0] port_bus_fault,
   output logic [NUM_PORTS-1:0] port_clock_enable,
   output logic [NUM_PORTS-1:0] port_clk,
   output logic irq
);

   logic [NUM_PORTS-1:0] run_gate_r;
   logic [NUM_PORTS-1:0] sleep_gate_r;
   logic [NUM_PORTS-1:0] dslp_gate_r;
   logic internal_osc_select_r;
   logic verify_fault_clear_r;
   logic regulator_reset_en_r;
   logic auto_gating_select_r;
   logic [`GCGSC_NUM_EVENTS-1:0] irq_status_r;
   logic [`GCGSC_NUM_EVENTS-1:0] irq_mask_r;
   logic [`GCGSC_NUM_EVENTS-1:0] irq_events;
   logic [NUM_PORTS-1:0] gate_nxt;
   logic [NUM_PORTS-1:0] gate_r;
   logic [31:0] rdata_nxt;
   logic addr_hit;
   logic wr_en;
   logic acc_en;
   gcgsc_pkg::gcgsc_state_t state_r;
   gcgsc_pkg::gcgsc_state_t state_nxt;
   gcgsc_pkg::gcgsc_clk_cfg_t saved_cfg_r;
   logic deep_int_osc_r;
   logic deep_exit;
   logic [2:0] fault_sync_r;
   logic [2:0] ldo_sync_r;
   logic fault_lvl_r;
   logic ldo_lvl_r;
   logic fault_lvl_d_r;
   logic ldo_lvl_d_r;
   logic fault_pending_r;

   // APB access phase, zero wait states
   assign acc_en = psel & penable;
   assign wr_en = acc_en & pwrite & pstrb[0] & addr_hit;
   assign pready = 1'b1;
   assign pslverr = acc_en & ~addr_hit;

   // Address decode and read mux; upper reserved bits read as zero
   always_comb begin
      addr_hit = 1'b1;
      rdata_nxt = 32'h00000000;
      case (paddr)
         `GCGSC_OFF_RUN_GATE: rdata_nxt[NUM_PORTS-1:0] = run_gate_r;
         `GCGSC_OFF_SLEEP_GATE: rdata_nxt[NUM_PORTS-1:0] = sleep_gate_r;
         `GCGSC_OFF_DSLP_GATE: rdata_nxt[NUM_PORTS-1:0] = dslp_gate_r;
         `GCGSC_OFF_DSLP_SRC: rdata_nxt[`GCGSC_BIT_INTERNAL_OSC_SELECT] = internal_osc_select_r;
         `GCGSC_OFF_VERIFY_CLR: rdata_nxt[`GCGSC_BIT_VERIFY_FAULT_CLEAR] = verify_fault_clear_r;
         `GCGSC_OFF_LDO_RST: rdata_nxt[`GCGSC_BIT_REGULATOR_RESET] = regulator_reset_en_r;
         `GCGSC_OFF_AUX_CTRL: rdata_nxt[`GCGSC_BIT_AUTO_GATING_SELECT] = auto_gating_select_r;
         `GCGSC_OFF_IRQ_STATUS: rdata_nxt[`GCGSC_NUM_EVENTS-1:0] = irq_status_r;
         `GCGSC_OFF_IRQ_MASK: rdata_nxt[`GCGSC_NUM_EVENTS-1:0] = irq_mask_r;
         default: addr_hit = 1'b0;
      endcase
   end

   // Registered read data, captured in the setup cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rdata_nxt;
      end
   end

   // Port gating enable copies
   always_ff @(posedge mclk) begin
      if (reset) begin
         run_gate_r <= `GCGSC_RST_GATE;
         sleep_gate_r <= `GCGSC_RST_GATE;
         dslp_gate_r <= `GCGSC_RST_GATE;
      end else if (wr_en) begin
         if (paddr == `GCGSC_OFF_RUN_GATE) begin
            run_gate_r <= pwdata[NUM_PORTS-1:0];
         end
         if (paddr == `GCGSC_OFF_SLEEP_GATE) begin
            sleep_gate_r <= pwdata[NUM_PORTS-1:0];
         end
         if (paddr == `GCGSC_OFF_DSLP_GATE) begin
            dslp_gate_r <= pwdata[NUM_PORTS-1:0];
         end
      end
   end

   // Single-bit control registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         internal_osc_select_r <= `GCGSC_RST_BIT;
         verify_fault_clear_r <= `GCGSC_RST_BIT;
         regulator_reset_en_r <= `GCGSC_RST_BIT;
         auto_gating_select_r <= `GCGSC_RST_BIT;
      end else if (wr_en) begin
         if (paddr == `GCGSC_OFF_DSLP_SRC) begin
            internal_osc_select_r <= pwdata[`GCGSC_BIT_INTERNAL_OSC_SELECT];
         end
         if (paddr == `GCGSC_OFF_VERIFY_CLR) begin
            verify_fault_clear_r <= pwdata[`GCGSC_BIT_VERIFY_FAULT_CLEAR];
         end
         if (paddr == `GCGSC_OFF_LDO_RST) begin
            regulator_reset_en_r <= pwdata[`GCGSC_BIT_REGULATOR_RESET];
         end
         if (paddr == `GCGSC_OFF_AUX_CTRL) begin
            auto_gating_select_r <= pwdata[`GCGSC_BIT_AUTO_GATING_SELECT];
         end
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_status_r <= `GCGSC_RST_EVENTS;
         irq_mask_r <= `GCGSC_RST_EVENTS;
      end else begin
         if (wr_en && paddr == `GCGSC_OFF_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~pwdata[`GCGSC_NUM_EVENTS-1:0]) | irq_events;
         end else begin
            irq_status_r <= irq_status_r | irq_events;
         end
         if (wr_en && paddr == `GCGSC_OFF_IRQ_MASK) begin
            irq_mask_r <= pwdata[`GCGSC_NUM_EVENTS-1:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

   // Pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge mclk) begin
      if (reset) begin
         fault_sync_r <= 3'h0;
         ldo_sync_r <= 3'h0;
         fault_lvl_r <= 1'b0;
         ldo_lvl_r <= 1'b0;
         fault_lvl_d_r <= 1'b0;
         ldo_lvl_d_r <= 1'b0;
      end else begin
         fault_sync_r <= {fault_sync_r[1:0], clk_verify_fault};
         ldo_sync_r <= {ldo_sync_r[1:0], regulator_unregulated};
         if (fault_sync_r[1] == fault_sync_r[2]) begin
            fault_lvl_r <= fault_sync_r[2];
         end
         if (ldo_sync_r[1] == ldo_sync_r[2]) begin
            ldo_lvl_r <= ldo_sync_r[2];
         end
         fault_lvl_d_r <= fault_lvl_r;
         ldo_lvl_d_r <= ldo_lvl_r;
      end
   end

   // Pending verify fault; a new fault wins over the clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         fault_pending_r <= 1'b0;
      end else if (fault_lvl_r & ~fault_lvl_d_r) begin
         fault_pending_r <= 1'b1;
      end else if (verify_fault_clear_r) begin
         fault_pending_r <= 1'b0;
      end
   end

   assign verify_fault_clear = verify_fault_clear_r;

   // Regulator fault reset request
   always_ff @(posedge mclk) begin
      if (reset) begin
         part_reset_req <= 1'b0;
      end else begin
         part_reset_req <= regulator_reset_en_r & ldo_lvl_r;
      end
   end

   // Power state from core sleep signals
   always_comb begin
      case (state_r)
         gcgsc_pkg::GCGSC_ST_RUN,
         gcgsc_pkg::GCGSC_ST_SLEEP,
         gcgsc_pkg::GCGSC_ST_DEEP: begin
            if (!core_sleeping) begin
               state_nxt = gcgsc_pkg::GCGSC_ST_RUN;
            end else if (core_sleep_deep) begin
               state_nxt = gcgsc_pkg::GCGSC_ST_DEEP;
            end else begin
               state_nxt = gcgsc_pkg::GCGSC_ST_SLEEP;
            end
         end
         default: state_nxt = gcgsc_pkg::GCGSC_ST_RUN;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= gcgsc_pkg::GCGSC_ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign deep_exit = (state_r == gcgsc_pkg::GCGSC_ST_DEEP) &&
                      (state_nxt != gcgsc_pkg::GCGSC_ST_DEEP);

   assign irq_events = {deep_exit, ldo_lvl_r & ~ldo_lvl_d_r, fault_lvl_r & ~fault_lvl_d_r};

   // Deep-sleep source capture at entry
   always_ff @(posedge mclk) begin
      if (reset) begin
         saved_cfg_r <= '0;
         deep_int_osc_r <= 1'b0;
      end else if (state_r != gcgsc_pkg::GCGSC_ST_DEEP &&
                   state_nxt == gcgsc_pkg::GCGSC_ST_DEEP) begin
         saved_cfg_r <= run_clk_cfg;
         deep_int_osc_r <= internal_osc_select_r;
      end else if (deep_exit) begin
         deep_int_osc_r <= 1'b0;
      end
   end

   // System clock selection: fault override, deep-sleep switch, restore
   always_ff @(posedge mclk) begin
      if (reset) begin
         sys_clk_cfg <= '0;
         osc_pwr <= '0;
      end else begin
         osc_pwr.int_osc_power_up <= fault_pending_r | (deep_int_osc_r &&
            state_nxt == gcgsc_pkg::GCGSC_ST_DEEP);
         osc_pwr.main_osc_power_down <= ~fault_pending_r & deep_int_osc_r &
            (state_nxt == gcgsc_pkg::GCGSC_ST_DEEP);
         if (fault_pending_r) begin
            sys_clk_cfg.src <= gcgsc_pkg::GCGSC_SRC_INT_OSC;
            sys_clk_cfg.sysdiv <= run_clk_cfg.sysdiv;
         end else if (deep_exit) begin
            sys_clk_cfg <= saved_cfg_r;
         end else if (deep_int_osc_r) begin
            sys_clk_cfg.src <= gcgsc_pkg::GCGSC_SRC_INT_OSC;
            sys_clk_cfg.sysdiv <= saved_cfg_r.sysdiv;
         end else if (state_r == gcgsc_pkg::GCGSC_ST_DEEP) begin
            sys_clk_cfg <= saved_cfg_r;
         end else begin
            sys_clk_cfg <= run_clk_cfg;
         end
      end
   end

   // Enable copy selection per power state
   always_comb begin
      gate_nxt = run_gate_r;
      if (auto_gating_select_r) begin
         case (state_nxt)
            gcgsc_pkg::GCGSC_ST_SLEEP: gate_nxt = sleep_gate_r;
            gcgsc_pkg::GCGSC_ST_DEEP: gate_nxt = dslp_gate_r;
            default: gate_nxt = run_gate_r;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         gate_r <= `GCGSC_RST_GATE;
      end else begin
         gate_r <= gate_nxt;
      end
   end

   assign port_clock_enable = gate_r;

   // Per-port latch clock gate and bus fault
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         logic en_lat;
         always_latch begin
            if (!mclk) begin
               en_lat = gate_r[gi];
            end
         end
         assign port_clk[gi] = mclk & en_lat;
         assign port_bus_fault[gi] = port_access[gi] & ~gate_r[gi];
      end
   endgenerate

endmodule : gcgsc_top

// ### verif/gcgsc_chk.sv
/* Checker for gcgsc_top, bound to its ports.
 Assumes the map header and package are compiled first. */
`timescale 1ns/1ps
`include "gcgsc_map.svh"
module gcgsc_chk #(
   parameter int NUM_PORTS = 5
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GCGSC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic core_sleeping,
   input wire logic core_sleep_deep,
   input wire gcgsc_pkg::gcgsc_clk_cfg_t sys_clk_cfg,
   input wire gcgsc_pkg::gcgsc_osc_pwr_t osc_pwr,
   input wire logic verify_fault_clear,
   input wire logic regulator_unregulated,
   input wire logic part_reset_req,
   input wire logic [NUM_PORTS-1:0] port_access,
   input wire logic [NUM_PORTS-1:0] port_bus_fault,
   input wire logic [NUM_PORTS-1:0] port_clock_enable,
   input wire logic [NUM_PORTS-1:0] port_clk
);
   logic wr;
   logic deep;
   logic ag_r;
   logic sel_r;
   logic [NUM_PORTS-1:0] run_r;
   assign wr = psel & penable & pwrite & pstrb[0];
   assign deep = core_sleeping & core_sleep_deep;
   // Mirrors of the run copy, auto gating and oscillator select
   always_ff @(posedge mclk) begin
      if (reset) begin
         run_r <= '0;
         ag_r <= 1'b0;
         sel_r <= 1'b0;
      end else if (wr) begin
         if (paddr == 12'h108) run_r <= pwdata[NUM_PORTS-1:0];
         if (paddr == 12'h170) ag_r <= pwdata[0];
         if (paddr == 12'h144) sel_r <= pwdata[0];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   fault_map_a: assert property (port_bus_fault == (port_access & ~port_clock_enable))
      else $error("bus fault mismatch");
   gate_reset_a: assert property ($past(reset) |-> port_clock_enable == '0)
      else $error("enable not cleared by reset");
   clk_follow_a: assert property (@(negedge mclk)
      port_clk == $past(port_clock_enable))
      else $error("gated clock mismatch");
   run_copy_a: assert property ((!ag_r && $stable(run_r)) [*3] |->
      port_clock_enable == run_r)
      else $error("run copy not applied");
   deep_osc_a: assert property ((deep && sel_r) [*3] |->
      sys_clk_cfg.src == gcgsc_pkg::GCGSC_SRC_INT_OSC && osc_pwr == 2'h3)
      else $error("deep sleep oscillator wrong");
   clr_write_a: assert property (wr && paddr == 12'h150 |=>
      verify_fault_clear == $past(pwdata[0]))
      else $error("verify clear not written");
   clr_hold_a: assert property (!(wr && paddr == 12'h150) |=>
      $stable(verify_fault_clear))
      else $error("verify clear changed");
   ldo_quiet_a: assert property (!regulator_unregulated [*6] |-> !part_reset_req)
      else $error("reset without fault");
   deep_c: cover property ((deep && sel_r) [*3]);
   clr_c: cover property (verify_fault_clear);
   rst_c: cover property (part_reset_req);
endmodule : gcgsc_chk
bind gcgsc_top gcgsc_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.mclk, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .core_sleeping, .core_sleep_deep, .sys_clk_cfg,
   .osc_pwr, .verify_fault_clear, .regulator_unregulated, .part_reset_req, .port_access,
   .port_bus_fault, .port_clock_enable, .port_clk);

// ### verif/gcgsc_top_tb.sv
/* Bench for gcgsc_top: APB tasks and directed sequences.
 Assumes the map header and package are compiled first. */
`timescale 1ns/1ps
module gcgsc_top_tb;
   logic mclk, reset, psel, penable, pwrite, pready, pslverr, rerr, irq;
   logic core_sleeping, core_sleep_deep, clk_verify_fault, regulator_unregulated;
   logic verify_fault_clear, part_reset_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb;
   logic [4:0] port_access, port_bus_fault, port_clock_enable, port_clk;
   gcgsc_pkg::gcgsc_clk_cfg_t run_clk_cfg, sys_clk_cfg;
   gcgsc_pkg::gcgsc_osc_pwr_t osc_pwr;
   int fail_count, checks_done;
   logic [11:0] offs [9] = '{12'h108, 12'h118, 12'h128, 12'h144, 12'h150, 12'h160,
      12'h170, 12'h180, 12'h184};
   localparam gcgsc_pkg::gcgsc_clk_cfg_t CFG = {gcgsc_pkg::GCGSC_SRC_PLL, 4'h3};
   gcgsc_top uut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .core_sleeping, .core_sleep_deep, .run_clk_cfg,
      .sys_clk_cfg, .osc_pwr, .clk_verify_fault, .verify_fault_clear,
      .regulator_unregulated, .part_reset_req, .port_access, .port_bus_fault,
      .port_clock_enable, .port_clk, .irq);
   task automatic end_sim;
      $display("Mismatches %0d, checks %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask : cyc
   // One APB transfer; waits for pready under a bound
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 16) begin
            chk("pready", 32'h1, 32'h0);
            end_sim();
         end
         @(posedge mclk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : xfer
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rdat);
   endtask : rd
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, core_sleeping, core_sleep_deep} = 5'h00;
      {clk_verify_fault, regulator_unregulated} = 2'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      port_access = 5'h00;
      run_clk_cfg = CFG;
      fail_count = 0;
      checks_done = 0;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      foreach (offs[i]) rd(offs[i], 32'h0);
      chk("enables", 5'h00, port_clock_enable);
      xfer(1'b1, 12'h108, 32'h00000015);
      pstrb <= 4'hE;
      xfer(1'b1, 12'h108, 32'h0);
      pstrb <= 4'hF;
      rd(12'h108, 32'h15);
      chk("enables", 5'h15, port_clock_enable);
      port_access <= 5'h1F;
      cyc(1);
      chk("bus fault", 5'h0A, port_bus_fault);
      port_access <= 5'h00;
      xfer(1'b1, 12'h118, 32'hA);
      xfer(1'b1, 12'h128, 32'h11);
      core_sleeping <= 1'b1;
      cyc(3);
      chk("enables", 5'h15, port_clock_enable);
      xfer(1'b1, 12'h170, 32'h1);
      cyc(1);
      chk("enables", 5'h0A, port_clock_enable);
      core_sleep_deep <= 1'b1;
      cyc(3);
      chk("enables", 5'h11, port_clock_enable);
      chk("int osc used", 32'h0, sys_clk_cfg.src == gcgsc_pkg::GCGSC_SRC_INT_OSC);
      chk("osc power", 2'h0, osc_pwr);
      {core_sleeping, core_sleep_deep} <= 2'h0;
      cyc(3);
      chk("enables", 5'h15, port_clock_enable);
      xfer(1'b1, 12'h144, 32'h1);
      rd(12'h144, 32'h1);
      {core_sleeping, core_sleep_deep} <= 2'h3;
      cyc(3);
      chk("source", gcgsc_pkg::GCGSC_SRC_INT_OSC, sys_clk_cfg.src);
      chk("osc power", 2'h3, osc_pwr);
      {core_sleeping, core_sleep_deep} <= 2'h0;
      cyc(3);
      chk("clock cfg", CFG, sys_clk_cfg);
      xfer(1'b1, 12'h184, 32'h7);
      clk_verify_fault <= 1'b1;
      cyc(8);
      chk("source", gcgsc_pkg::GCGSC_SRC_INT_OSC, sys_clk_cfg.src);
      chk("irq", 1'h1, irq);
      rd(12'h180, 32'h5);
      clk_verify_fault <= 1'b0;
      xfer(1'b1, 12'h150, 32'h1);
      chk("verify clear", 1'h1, verify_fault_clear);
      rd(12'h150, 32'h1);
      xfer(1'b1, 12'h150, 32'h0);
      chk("clock cfg", CFG, sys_clk_cfg);
      xfer(1'b1, 12'h180, 32'h7);
      rd(12'h180, 32'h0);
      chk("irq", 1'h0, irq);
      xfer(1'b1, 12'h184, 32'h0);
      regulator_unregulated <= 1'b1;
      cyc(8);
      chk("part reset", 1'h0, part_reset_req);
      chk("irq", 1'h0, irq);
      rd(12'h180, 32'h2);
      xfer(1'b1, 12'h160, 32'h1);
      xfer(1'b1, 12'h184, 32'h2);
      cyc(2);
      chk("part reset", 1'h1, part_reset_req);
      chk("irq", 1'h1, irq);
      regulator_unregulated <= 1'b0;
      xfer(1'b1, 12'h108, 32'h0);
      port_access <= 5'h1F;
      xfer(1'b0, 12'h200, 32'h0);
      chk("slave error", 1'h1, rerr);
      chk("read data", 32'h0, rdat);
      chk("bus fault", 5'h1F, port_bus_fault);
      end_sim();
   end
endmodule : gcgsc_top_tb
